// >>> core/udc_core_ctrl.sv
// Summary of operation
// - disabling endpoint keeps its memory reservation
// - freeing memory slides only next endpoint down
// - larger reallocation slides next endpoint, overlap allowed
// - endpoint zero data survives other endpoint changes
// - same-size reallocation leaves higher endpoints unmoved
// - config ok set despite memory overlap
// - suspend idles pad, wakeup reactivates pad
// - detach holds pad idle until cleared
// - pad writes need enable, reads always work
// - macro enable bit seven enables, clear resets
// - freeze bit five gates clocks, reserved zero
// - direct access bit reads dpram at address
// - low direct address byte, read write, zero
// - drive select: normal, reserved, usb, ps2
// - drive value bits set dplus and dminus
// - bits three to zero show pin levels
// - reset: clock frozen, detached, banks cleared
// - pullup connects once detach is cleared
// - idle low power after reset without pll
// - five endpoints, up to 64 bytes, dual on 3-4
// - endpoint reset clears banks and pointers
// - eleven bit address writable while held in reset
// - endpoint reset keeps toggle, config and enable
`timescale 1ns/10ps
`default_nettype none
`include "udc_defs.svh"

module udc_core_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_suspend_seen,
	input wire logic bus_activity_seen,
	input wire logic dplus_in,
	input wire logic dminus_in,
	input wire logic ps2_clock_in,
	input wire logic ps2_data_in,
	output udc_pkg::udc_pad_drive_t pad_drive,
	output logic pad_low_power,
	output logic transceiver_enable,
	output logic dplus_pullup,
	output logic usb_clock_run,
	output logic [4:0] ep_soft_reset
);
	import udc_pkg::*;

	// software visible state
	logic usb_macro_enable; // controller enable
	logic freeze_usb_clock; // clock gate request
	logic dpram_direct_access; // data port reads raw dpram
	logic [10:0] dpram_direct_address; // full direct address
	logic [1:0] pad_direct_drive_select; // drive mode
	logic [1:0] pad_direct_drive_value; // dplus, dminus levels
	logic detach; // pullup off while set
	logic suspend_flag; // bus suspend seen
	logic wakeup_flag; // bus activity seen
	logic [2:0] ep_select; // endpoint the ports address
	udc_ep_cfg_t ep_cfg [`UDC_EP_COUNT]; // per endpoint config
	logic [8:0] ep_base [`UDC_EP_COUNT]; // region start in dpram
	logic [8:0] next_base [`UDC_EP_COUNT]; // allocator result
	logic [6:0] ep_ptr [`UDC_EP_COUNT]; // fifo byte pointer
	logic [7:0] dpram [`UDC_DPRAM_BYTES]; // endpoint memory
	udc_state_t state; // power state
	logic [31:0] rd_q; // read data flop
	logic err_q; // unmapped flag for the access phase

	// bus decode
	logic wr_done; // write takes effect this edge
	logic rd_setup; // read setup cycle, data is fetched
	logic rd_done; // read completes this edge
	logic mapped; // address hits a register
	logic cfg_wr; // endpoint config write accepted
	logic sel_ok; // selected endpoint exists
	udc_ep_cfg_t cfg_w; // config as written
	logic [10:0] fifo_addr; // selected endpoint fifo address
	logic [7:0] direct_byte; // byte at the direct address, for checking

	assign wr_done = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign rd_done = psel && penable && !pwrite;
	assign sel_ok = ep_select < 3'(`UDC_EP_COUNT);
	assign cfg_wr = wr_done && paddr == `UDC_OFF_EP_CONFIG && usb_macro_enable && sel_ok;
	// dual bank is only kept on the ping-pong capable endpoints
	assign cfg_w = '{dual_bank: pwdata[4] && ep_select >= 3'(`UDC_FIRST_DUAL_EP),
		size_code: pwdata[3:2], memory_a: pwdata[1], enable: pwdata[0]};

	// bytes a configured endpoint occupies, banks counted
	function automatic logic [8:0] ep_bytes(input udc_ep_cfg_t c);
		logic [8:0] s;
		s = `UDC_EP_MIN_BYTES << c.size_code;
		ep_bytes = c.dual_bank ? 9'(s << 1) : s;
	endfunction

	// out of range addresses read as zero instead of wrapping
	function automatic logic [7:0] mem_rd(input logic [10:0] a);
		mem_rd = (a < 11'(`UDC_DPRAM_BYTES)) ? dpram[a[7:0]] : `UDC_RST_BYTE;
	endfunction

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			`UDC_OFF_GEN_CTRL, `UDC_OFF_DP_CTRL_HI, `UDC_OFF_DP_ADDR_LO,
			`UDC_OFF_PAD_DRIVE, `UDC_OFF_DEV_CTRL, `UDC_OFF_DEV_FLAGS,
			`UDC_OFF_EP_RESET, `UDC_OFF_EP_SELECT, `UDC_OFF_EP_CONFIG,
			`UDC_OFF_EP_DATA, `UDC_OFF_EP_BASE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign fifo_addr = 11'(ep_base[ep_select] + 9'(ep_ptr[ep_select]));
	assign direct_byte = mem_rd(dpram_direct_address);

	// zero wait state slave, handshake is combinational
	assign pready = psel && penable;
	assign pslverr = psel && penable && err_q;
	assign prdata = rd_q;

	// general control, writable even while the macro is disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			usb_macro_enable <= 1'b0;
			freeze_usb_clock <= `UDC_RST_FREEZE;
		end else if (wr_done && paddr == `UDC_OFF_GEN_CTRL) begin
			usb_macro_enable <= pwdata[`UDC_BIT_MACRO_EN];
			freeze_usb_clock <= pwdata[`UDC_BIT_FREEZE];
		end
	end

	// direct dpram addressing survives macro reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dpram_direct_access <= 1'b0;
			dpram_direct_address <= 11'h000;
		end else if (wr_done && paddr == `UDC_OFF_DP_CTRL_HI) begin
			dpram_direct_access <= pwdata[`UDC_BIT_DP_ACCESS];
			dpram_direct_address[10:8] <= pwdata[2:0];
		end else if (wr_done && paddr == `UDC_OFF_DP_ADDR_LO) begin
			dpram_direct_address[7:0] <= pwdata[7:0];
		end
	end

	// pad drive fields, ignored while the controller is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_direct_drive_select <= UDC_DRV_NORMAL;
			pad_direct_drive_value <= 2'b00;
		end else if (wr_done && paddr == `UDC_OFF_PAD_DRIVE && usb_macro_enable) begin
			pad_direct_drive_select <= pwdata[7:6];
			pad_direct_drive_value <= pwdata[5:4];
		end
	end

	// detach, forced back on by a macro reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detach <= `UDC_RST_DETACH;
		end else if (!usb_macro_enable) begin
			detach <= `UDC_RST_DETACH;
		end else if (wr_done && paddr == `UDC_OFF_DEV_CTRL) begin
			detach <= pwdata[`UDC_BIT_DETACH];
		end
	end

	// bus event flags; a new event beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			suspend_flag <= 1'b0;
			wakeup_flag <= 1'b0;
		end else if (!usb_macro_enable) begin
			suspend_flag <= 1'b0;
			wakeup_flag <= 1'b0;
		end else begin
			// suspend timing needs the running clock, wakeup does not
			if (bus_suspend_seen && !freeze_usb_clock) begin
				suspend_flag <= 1'b1;
			end else if (bus_activity_seen) begin
				suspend_flag <= 1'b0;
			end else if (wr_done && paddr == `UDC_OFF_DEV_FLAGS && pwdata[`UDC_BIT_SUSPEND]) begin
				suspend_flag <= 1'b0;
			end
			if (bus_activity_seen) begin
				wakeup_flag <= 1'b1;
			end else if (bus_suspend_seen && !freeze_usb_clock) begin
				wakeup_flag <= 1'b0;
			end else if (wr_done && paddr == `UDC_OFF_DEV_FLAGS && pwdata[`UDC_BIT_WAKEUP]) begin
				wakeup_flag <= 1'b0;
			end
		end
	end

	// power state follows enable and suspend
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= UDC_ST_OFF;
		end else begin
			case (state)
				UDC_ST_OFF: state <= usb_macro_enable ? UDC_ST_ACTIVE : UDC_ST_OFF;
				UDC_ST_ACTIVE: begin
					if (!usb_macro_enable) begin
						state <= UDC_ST_OFF;
					end else if (suspend_flag) begin
						state <= UDC_ST_SUSPEND;
					end
				end
				UDC_ST_SUSPEND: begin
					if (!usb_macro_enable) begin
						state <= UDC_ST_OFF;
					end else if (!suspend_flag) begin
						state <= UDC_ST_ACTIVE;
					end
				end
				default: state <= UDC_ST_OFF;
			endcase
		end
	end

	// endpoint select register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_select <= 3'h0;
		end else if (wr_done && paddr == `UDC_OFF_EP_SELECT) begin
			ep_select <= pwdata[2:0];
		end
	end

	// allocator: lower neighbour fixes the start, only the next one slides
	always_comb begin
		logic [8:0] lower_end;
		logic found;
		int k;
		lower_end = 9'h000;
		found = 1'b0;
		k = int'(ep_select);
		next_base = ep_base;
		if (cfg_wr && cfg_w.memory_a && !ep_cfg[ep_select].memory_a) begin
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				if (i < k && ep_cfg[i].memory_a) begin
					lower_end = 9'(ep_base[i] + ep_bytes(ep_cfg[i]));
				end
			end
			next_base[ep_select] = lower_end;
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				if (i > k && ep_cfg[i].memory_a && !found) begin
					next_base[i] = 9'(lower_end + ep_bytes(cfg_w));
					found = 1'b1;
				end
			end
		end else if (cfg_wr && !cfg_w.memory_a && ep_cfg[ep_select].memory_a) begin
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				if (i > k && ep_cfg[i].memory_a && !found) begin
					next_base[i] = ep_base[ep_select];
					found = 1'b1;
				end
			end
		end
	end

	// endpoint config and region bases, cleared by a macro reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				ep_cfg[i] <= '0;
				ep_base[i] <= 9'h000;
			end
		end else if (!usb_macro_enable) begin
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				ep_cfg[i] <= '0;
				ep_base[i] <= 9'h000;
			end
		end else begin
			ep_base <= next_base;
			if (cfg_wr) begin
				// clearing enable alone leaves memory_a and the base alone
				ep_cfg[ep_select] <= cfg_w;
			end
		end
	end

	// endpoint reset strobes, one cycle, bits read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_soft_reset <= 5'h00;
		end else if (wr_done && paddr == `UDC_OFF_EP_RESET && usb_macro_enable) begin
			ep_soft_reset <= pwdata[4:0];
		end else begin
			ep_soft_reset <= 5'h00;
		end
	end

	// fifo pointers: reset by endpoint reset, disable or region change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				ep_ptr[i] <= 7'h00;
			end
		end else begin
			for (int i = 0; i < `UDC_EP_COUNT; i++) begin
				if (!usb_macro_enable || ep_soft_reset[i] || !ep_cfg[i].enable) begin
					ep_ptr[i] <= 7'h00;
				end else if (next_base[i] != ep_base[i]) begin
					ep_ptr[i] <= 7'h00;
				end else if (i == int'(ep_select) && paddr == `UDC_OFF_EP_DATA &&
					psel && penable && !dpram_direct_access) begin
					// wraps at the region size, both banks counted, so the region never spills over
					ep_ptr[i] <= (9'(ep_ptr[i]) + 9'h001 == ep_bytes(ep_cfg[i])) ?
						7'h00 : 7'(ep_ptr[i] + 7'h01);
				end
			end
		end
	end

	// dpram has no reset, contents survive a macro reset
	always_ff @(posedge pclk) begin
		if (wr_done && paddr == `UDC_OFF_EP_DATA) begin
			if (dpram_direct_access && dpram_direct_address < 11'(`UDC_DPRAM_BYTES)) begin
				dpram[dpram_direct_address[7:0]] <= pwdata[7:0];
			end else if (!dpram_direct_access && usb_macro_enable && sel_ok &&
				ep_cfg[ep_select].enable && fifo_addr < 11'(`UDC_DPRAM_BYTES)) begin
				dpram[fifo_addr[7:0]] <= pwdata[7:0];
			end
		end
	end

	// read data is fetched in the setup cycle and held for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (psel && !penable) begin
			err_q <= !mapped;
			rd_q <= 32'h0000_0000;
			if (rd_setup) begin
				case (paddr)
					`UDC_OFF_GEN_CTRL: rd_q[7:0] <= {usb_macro_enable, 1'b0,
						freeze_usb_clock, 5'b00000};
					`UDC_OFF_DP_CTRL_HI: rd_q[7:0] <= {dpram_direct_access, 4'h0,
						dpram_direct_address[10:8]};
					`UDC_OFF_DP_ADDR_LO: rd_q[7:0] <= dpram_direct_address[7:0];
					`UDC_OFF_PAD_DRIVE: rd_q[7:0] <= {pad_direct_drive_select,
						pad_direct_drive_value, ps2_clock_in, ps2_data_in,
						dplus_in, dminus_in};
					`UDC_OFF_DEV_CTRL: rd_q[0] <= detach;
					`UDC_OFF_DEV_FLAGS: rd_q[1:0] <= {wakeup_flag, suspend_flag};
					`UDC_OFF_EP_SELECT: rd_q[2:0] <= ep_select;
					`UDC_OFF_EP_CONFIG: begin
						if (sel_ok) begin
							rd_q[4:0] <= ep_cfg[ep_select];
							rd_q[`UDC_BIT_CFG_OK] <= ep_cfg[ep_select].memory_a;
						end
					end
					`UDC_OFF_EP_DATA: rd_q[7:0] <= dpram_direct_access ?
						mem_rd(dpram_direct_address) : mem_rd(fifo_addr);
					`UDC_OFF_EP_BASE: rd_q[8:0] <= sel_ok ? ep_base[ep_select] : 9'h000;
					default: rd_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// pad and clock controls
	assign usb_clock_run = usb_macro_enable && !freeze_usb_clock;
	assign transceiver_enable = usb_macro_enable;
	assign dplus_pullup = usb_macro_enable && !detach;
	assign pad_low_power = detach || state != UDC_ST_ACTIVE;
	always_comb begin
		pad_drive = '0;
		if (usb_macro_enable && pad_direct_drive_select[1]) begin
			pad_drive.ps2_levels = pad_direct_drive_select == UDC_DRV_PS2;
			pad_drive.dplus_oe = 1'b1;
			pad_drive.dminus_oe = 1'b1;
			pad_drive.dplus_out = pad_direct_drive_value[1];
			pad_drive.dminus_out = pad_direct_drive_value[0];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ep0_fixed_a: assert property (ep_base[0] == 9'h000)
		else $error("endpoint zero region moved");
	detach_idle_a: assert property (detach |-> pad_low_power && !dplus_pullup)
		else $error("pad not idle while detached");
	suspend_idle_a: assert property ($rose(suspend_flag) |=> pad_low_power)
		else $error("suspend did not idle the pad");
	wake_active_a: assert property ($rose(wakeup_flag) && !detach && usb_macro_enable
		##1 usb_macro_enable && !detach |-> !pad_low_power)
		else $error("wakeup did not reactivate the pad");
	pullup_attach_a: assert property ($fell(detach) && usb_macro_enable |-> dplus_pullup)
		else $error("pullup missing after attach");
	macro_reset_a: assert property ($fell(usb_macro_enable) |=> detach && !usb_clock_run
		&& ep_cfg[0] == '0)
		else $error("disable did not reset the macro");
	drive_gated_a: assert property (!usb_macro_enable |-> !pad_drive.dplus_oe
		&& !pad_drive.dminus_oe)
		else $error("pad driven while disabled");
	cfg_ok_set_a: assert property (cfg_wr && pwdata[1] ##2 rd_setup
		&& paddr == `UDC_OFF_EP_CONFIG && $stable(ep_select) && usb_macro_enable
		|=> rd_q[`UDC_BIT_CFG_OK])
		else $error("config ok not reported");
	ep_reset_ptr_a: assert property (ep_soft_reset[0] |=> ep_ptr[0] == 7'h00
		&& ep_cfg[0] == $past(ep_cfg[0]))
		else $error("endpoint reset wrong");
	direct_read_a: assert property (rd_setup && paddr == `UDC_OFF_EP_DATA
		&& dpram_direct_access |=> rd_q[7:0] == $past(direct_byte))
		else $error("direct read data wrong");
	slide_down_a: assert property (cfg_wr && ep_select == 3'h2 && !pwdata[1]
		&& ep_cfg[2].memory_a && ep_cfg[3].memory_a |=> ep_base[3] == $past(ep_base[2])
		&& ep_base[4] == $past(ep_base[4]))
		else $error("release slide wrong");
	unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr)
		else $error("unmapped access not flagged");

	suspend_wake_c: cover property (suspend_flag ##[1:50] wakeup_flag);
	direct_read_c: cover property (rd_done && paddr == `UDC_OFF_EP_DATA && dpram_direct_access);
	endpoint_memory_a_top_c: cover property (cfg_wr && ep_select == 3'h4 && pwdata[1]);
	ps2_drive_c: cover property (pad_drive.ps2_levels && pad_drive.dplus_oe);
endmodule
`default_nettype wire

// >>> core/udc_defs.svh
`ifndef UDC_DEFS_SVH
`define UDC_DEFS_SVH

// register byte offsets on the apb window
`define UDC_OFF_GEN_CTRL 8'h00
`define UDC_OFF_DP_CTRL_HI 8'h04
`define UDC_OFF_DP_ADDR_LO 8'h08
`define UDC_OFF_PAD_DRIVE 8'h0C
`define UDC_OFF_DEV_CTRL 8'h10
`define UDC_OFF_DEV_FLAGS 8'h14
`define UDC_OFF_EP_RESET 8'h18
`define UDC_OFF_EP_SELECT 8'h1C
`define UDC_OFF_EP_CONFIG 8'h20
`define UDC_OFF_EP_DATA 8'h24
`define UDC_OFF_EP_BASE 8'h28

// field positions
`define UDC_BIT_MACRO_EN 7
`define UDC_BIT_FREEZE 5
`define UDC_BIT_DP_ACCESS 7
`define UDC_BIT_DETACH 0
`define UDC_BIT_SUSPEND 0
`define UDC_BIT_WAKEUP 1
`define UDC_BIT_CFG_OK 7

// reset values
`define UDC_RST_FREEZE 1'b1
`define UDC_RST_DETACH 1'b1
`define UDC_RST_BYTE 8'h00

// memory geometry
`define UDC_DPRAM_BYTES 176
`define UDC_EP_COUNT 5
`define UDC_EP_MIN_BYTES 9'h008
`define UDC_FIRST_DUAL_EP 3

`endif

// >>> core/udc_pkg.sv
package udc_pkg;

	// controller power state, gray along off -> active -> suspend
	typedef enum logic [1:0] {
		UDC_ST_OFF = 2'b00,
		UDC_ST_ACTIVE = 2'b01,
		UDC_ST_SUSPEND = 2'b11
	} udc_state_t;

	// pad direct drive modes
	typedef enum logic [1:0] {
		UDC_DRV_NORMAL = 2'b00,
		UDC_DRV_RESERVED = 2'b01,
		UDC_DRV_USB = 2'b10,
		UDC_DRV_PS2 = 2'b11
	} udc_drive_mode_t;

	// endpoint configuration word, low bits of the config register
	typedef struct packed {
		logic dual_bank;
		logic [1:0] size_code;
		logic memory_a;
		logic enable;
	} udc_ep_cfg_t;

	// software pad drive towards the pad ring
	typedef struct packed {
		logic ps2_levels;
		logic dplus_oe;
		logic dplus_out;
		logic dminus_oe;
		logic dminus_out;
	} udc_pad_drive_t;

endpackage

// >>> sim/udc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module udc_host_model (
	input wire logic pclk,
	input wire udc_pkg::udc_pad_drive_t pad_drive,
	output logic bus_suspend_seen,
	output logic bus_activity_seen,
	output logic dplus_in,
	output logic dminus_in,
	output logic ps2_clock_in,
	output logic ps2_data_in
);
	import udc_pkg::*;

	logic host_dp; // host level on d+, idle j keeps it high
	logic host_dm; // host level on d-, idle j keeps it low

	// line starts idle with no event pending
	initial begin
		host_dp = 1'b1;
		host_dm = 1'b0;
		bus_suspend_seen = 1'b0;
		bus_activity_seen = 1'b0;
	end

	// the driving pad wins over the host, so readback shows the drive
	assign dplus_in = pad_drive.dplus_oe ? pad_drive.dplus_out : host_dp;
	assign dminus_in = pad_drive.dminus_oe ? pad_drive.dminus_out : host_dm;
	// ps2 pins share the same two pads
	assign ps2_clock_in = dplus_in;
	assign ps2_data_in = dminus_in;

	// line logic reports a long idle as a one-cycle event
	task suspend_evt;
		bus_suspend_seen <= 1'b1;
		@(posedge pclk);
		bus_suspend_seen <= 1'b0;
	endtask

	// short k state, seen as non-idle activity
	task resume_evt;
		host_dp <= 1'b0;
		host_dm <= 1'b1;
		bus_activity_seen <= 1'b1;
		@(posedge pclk);
		bus_activity_seen <= 1'b0;
		@(posedge pclk);
		host_dp <= 1'b1;
		host_dm <= 1'b0;
	endtask
endmodule

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "udc_defs.svh"

module tb;
	import udc_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic sus_seen, act_seen, dp_in, dm_in, sck_in, dat_in;
	udc_pad_drive_t pad_drive;
	logic pad_low_power, transceiver_enable, dplus_pullup, usb_clock_run;
	logic [4:0] ep_soft_reset;
	logic [4:0] rst_seen; // sticky record of endpoint reset pulses
	logic [8:0] outs; // pad drive plus power outputs, one bundle
	logic [32:0] exp_q[$]; // {slave error, read data} per read
	logic [7:0] ep0_data[8];
	logic [7:0] base_tbl[5];
	logic [1:0] m, v;
	int n_errors, compares;

	assign outs = {pad_drive, pad_low_power, transceiver_enable, dplus_pullup, usb_clock_run};

	udc_core_ctrl udc_core_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_suspend_seen(sus_seen), .bus_activity_seen(act_seen),
		.dplus_in(dp_in), .dminus_in(dm_in), .ps2_clock_in(sck_in),
		.ps2_data_in(dat_in), .pad_drive(pad_drive), .pad_low_power(pad_low_power),
		.transceiver_enable(transceiver_enable), .dplus_pullup(dplus_pullup),
		.usb_clock_run(usb_clock_run), .ep_soft_reset(ep_soft_reset));

	udc_host_model udc_host_model_i (.pclk(pclk), .pad_drive(pad_drive),
		.bus_suspend_seen(sus_seen), .bus_activity_seen(act_seen),
		.dplus_in(dp_in), .dminus_in(dm_in), .ps2_clock_in(sck_in),
		.ps2_data_in(dat_in));

	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task finish_test;
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk_read(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task chk_out(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t outputs %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; an idle cycle after it keeps drives single per step
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	// note the expected answer, then read
	task rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
		exp_q.push_back({err, 24'h00_0000, e});
		apb(1'b0, a, 8'h00);
	endtask

	task ep_cfg(input logic [7:0] k, input logic [7:0] c);
		wr(`UDC_OFF_EP_SELECT, k);
		wr(`UDC_OFF_EP_CONFIG, c);
	endtask

	task ep_base(input logic [7:0] k, input logic [7:0] b);
		wr(`UDC_OFF_EP_SELECT, k);
		rd(`UDC_OFF_EP_BASE, b);
	endtask

	// read checker: oldest note against each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk_read({pslverr, prdata}, exp_q.pop_front());
	end

	// pulses last one cycle, so catch them as they pass
	always @(posedge pclk) begin
		rst_seen <= rst_seen | ep_soft_reset;
	end

	// watchdog, well above the length of the sequence
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		finish_test();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rst_seen = 5'h00;
		n_errors = 0;
		compares = 0;
		base_tbl = '{8'h00, 8'h08, 8'h18, 8'h20, 8'h30};
		void'($urandom(39100));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// defaults after reset: detached, idle pad, clocks off
		chk_out(outs, 9'h008);
		rd(`UDC_OFF_GEN_CTRL, 8'h20);
		rd(`UDC_OFF_DP_ADDR_LO, 8'h00);
		rd(`UDC_OFF_PAD_DRIVE, 8'h0A);
		rd(`UDC_OFF_DEV_CTRL, 8'h01);
		rd(8'h30, 8'h00, 1'b1);
		// dpram address registers work while the controller is off
		ep0_data[0] = 8'($urandom);
		wr(`UDC_OFF_DP_CTRL_HI, 8'h85);
		wr(`UDC_OFF_DP_ADDR_LO, ep0_data[0]);
		rd(`UDC_OFF_DP_CTRL_HI, 8'h85);
		rd(`UDC_OFF_DP_ADDR_LO, ep0_data[0]);
		wr(`UDC_OFF_PAD_DRIVE, 8'hB0);
		rd(`UDC_OFF_PAD_DRIVE, 8'h0A);
		// enable with freeze, then without
		wr(`UDC_OFF_GEN_CTRL, 8'hFF);
		rd(`UDC_OFF_GEN_CTRL, 8'hA0);
		chk_out(outs, 9'h00C);
		wr(`UDC_OFF_GEN_CTRL, 8'h80);
		chk_out(outs, 9'h00D);
		// every drive mode with every value pair
		for (int i = 0; i < 16; i++) begin
			m = i[3:2];
			v = i[1:0];
			wr(`UDC_OFF_PAD_DRIVE, {m, v, 4'h0});
			if (m[1])
				rd(`UDC_OFF_PAD_DRIVE, {m, v, v, v});
			else
				rd(`UDC_OFF_PAD_DRIVE, {m, v, 4'hA});
			chk_out(outs, {m == 2'b11, m[1], m[1] & v[1], m[1], m[1] & v[0], 4'hD});
		end
		wr(`UDC_OFF_PAD_DRIVE, 8'h00);
		// attach, suspend and wake
		wr(`UDC_OFF_DEV_CTRL, 8'h00);
		chk_out(outs, 9'h007);
		udc_host_model_i.suspend_evt();
		repeat (3) @(posedge pclk);
		rd(`UDC_OFF_DEV_FLAGS, 8'h01);
		chk_out(outs, 9'h00F);
		udc_host_model_i.resume_evt();
		repeat (3) @(posedge pclk);
		rd(`UDC_OFF_DEV_FLAGS, 8'h02);
		chk_out(outs, 9'h007);
		wr(`UDC_OFF_DEV_CTRL, 8'h01);
		chk_out(outs, 9'h00D);
		wr(`UDC_OFF_DEV_CTRL, 8'h00);
		// endpoint 0 gets data, then the rest in ascending order
		// fifo mode, so the data lands in endpoint 0's region
		wr(`UDC_OFF_DP_CTRL_HI, 8'h00);
		ep_cfg(8'h00, 8'h03);
		for (int i = 0; i < 8; i++) begin
			ep0_data[i] = 8'($urandom);
			wr(`UDC_OFF_EP_DATA, ep0_data[i]);
		end
		ep_cfg(8'h01, 8'h07);
		ep_cfg(8'h02, 8'h03);
		ep_cfg(8'h03, 8'h07);
		ep_cfg(8'h04, 8'h03);
		for (int k = 0; k < 5; k++)
			ep_base(8'(k), base_tbl[k]);
		ep_cfg(8'h02, 8'h02);
		ep_base(8'h02, 8'h18);
		rd(`UDC_OFF_EP_CONFIG, 8'h82);
		ep_cfg(8'h02, 8'h00);
		ep_cfg(8'h02, 8'h03);
		ep_base(8'h03, 8'h20);
		ep_base(8'h04, 8'h30);
		ep_cfg(8'h02, 8'h00);
		ep_base(8'h03, 8'h18);
		ep_base(8'h04, 8'h30);
		ep_cfg(8'h02, 8'h0B);
		rd(`UDC_OFF_EP_CONFIG, 8'h8B);
		ep_base(8'h02, 8'h18);
		ep_base(8'h03, 8'h38);
		ep_base(8'h04, 8'h30);
		rd(`UDC_OFF_EP_CONFIG, 8'h83);
		// endpoint 0 data still intact, seen through direct access
		wr(`UDC_OFF_DP_CTRL_HI, 8'h80);
		for (int i = 0; i < 8; i++) begin
			wr(`UDC_OFF_DP_ADDR_LO, 8'(i));
			rd(`UDC_OFF_EP_DATA, ep0_data[i]);
		end
		wr(`UDC_OFF_DP_CTRL_HI, 8'h00);
		wr(`UDC_OFF_EP_SELECT, 8'h00);
		rd(`UDC_OFF_EP_DATA, ep0_data[0]);
		rd(`UDC_OFF_EP_DATA, ep0_data[1]);
		wr(`UDC_OFF_EP_RESET, 8'h01);
		// the sticky copy settles one edge after the pulse
		@(posedge pclk);
		chk_out({4'h0, rst_seen}, 9'h001);
		rd(`UDC_OFF_EP_DATA, ep0_data[0]);
		rd(`UDC_OFF_EP_CONFIG, 8'h83);
		// disable resets the controller but pins still read
		wr(`UDC_OFF_GEN_CTRL, 8'h00);
		// detach and power state follow the enable one edge later
		@(posedge pclk);
		chk_out(outs, 9'h008);
		rd(`UDC_OFF_DEV_CTRL, 8'h01);
		rd(`UDC_OFF_PAD_DRIVE, 8'h0A);
		repeat (2) @(posedge pclk);
		finish_test();
	end
endmodule

`default_nettype wire
